// ---- sac_pkg.sv ----
// constants, register map and field layout for the converter calibration control
// Notes on behaviour
// - averaging code 00 averages fifteen readings
// - busy reads high while converting or calibrating
// - type bit: zero offset, one gain calibration
// - start bit launches the selected calibration
// - hardware clears start bit when calibration ends
// - each conversion: track phase, then hold phase
// - final approximation value latched as result
// - phases and bit trials sequence without software
// - acquisition and conversion timing are programmable
// - results carry twelve bits of resolution
package sac_pkg;
	// byte offsets on the register bus
	localparam logic [7:0] OFF_CAL_CTRL = 8'h00;
	localparam logic [7:0] OFF_TIMING = 8'h04;
	localparam logic [7:0] OFF_CONV = 8'h08;
	localparam logic [7:0] OFF_RESULT = 8'h0C;
	localparam logic [7:0] OFF_OFS_COEF = 8'h10;
	localparam logic [7:0] OFF_GAIN_COEF = 8'h14;
	// data widths
	localparam int RES_W = 12;
	localparam int SUM_W = 18;
	localparam int DIV_W = 8;
	localparam int ACQ_W = 2;
	localparam int CNT_W = 6;
	// calibration control field positions
	localparam int CC_BUSY = 7;
	localparam int CC_AVG_HI = 5;
	localparam int CC_AVG_LO = 4;
	localparam int CC_ARM = 2;
	localparam int CC_TYPE = 1;
	localparam int CC_START = 0;
	localparam logic [7:0] CAL_CTRL_RST = 8'h00;
	localparam logic [7:0] CAL_CTRL_WMASK = 8'h37;
	// timing register fields and reset values
	localparam int TM_ACQ_LSB = 0;
	localparam int TM_DIV_LSB = 8;
	localparam logic [1:0] ACQ_RST = 2'h2;
	localparam logic [7:0] DIV_RST = 8'h07;
	// number of readings per averaging code
	localparam logic [5:0] AVG_N00 = 6'h0F;
	localparam logic [5:0] AVG_N01 = 6'h01;
	localparam logic [5:0] AVG_N10 = 6'h1F;
	localparam logic [5:0] AVG_N11 = 6'h3F;
	// calibration input select driven to the analog front end
	localparam logic [1:0] CALM_NONE = 2'h0;
	localparam logic [1:0] CALM_ZERO = 2'h1;
	localparam logic [1:0] CALM_FULL = 2'h2;
endpackage

// ---- sac_conv_if.sv ----
// carrier between the control block and the approximation engine
`timescale 1ns/1ps
`default_nettype none
interface sac_conv_if;
	logic start;
	logic [sac_pkg::ACQ_W-1:0] acq_sel;
	logic [sac_pkg::DIV_W-1:0] clk_div;
	logic cmp;
	logic track;
	logic [sac_pkg::RES_W-1:0] dac;
	logic [sac_pkg::RES_W-1:0] result;
	logic done;
	modport ctrl (output start, acq_sel, clk_div, cmp, input track, dac, result, done);
	modport eng (input start, acq_sel, clk_div, cmp, output track, dac, result, done);
endinterface
`default_nettype wire

// ---- sac_sar_engine.sv ----
// successive approximation engine: track phase, then twelve bit trials
`timescale 1ns/1ps
`default_nettype none
module sac_sar_engine (
	input wire logic i_clock,
	input wire logic i_sys_rst,
	sac_conv_if.eng cif
);
	typedef enum logic [2:0] {E_IDLE = 3'b001, E_TRACK = 3'b010, E_CONV = 3'b100} sac_eng_t;
	localparam int RW = sac_pkg::RES_W;
	sac_eng_t st_r, st_nxt;
	logic [sac_pkg::DIV_W-1:0] div_cnt_r;
	logic [sac_pkg::ACQ_W-1:0] acq_cnt_r;
	logic [RW-1:0] sar_r, bit_r, res_r;
	logic done_r, track_r;
	// one tick per converter clock, period clk_div+1 core cycles
	wire tick = (div_cnt_r == cif.clk_div);
	wire acq_end = tick && (acq_cnt_r == cif.acq_sel);
	wire trial_end = tick && bit_r[0];
	wire [RW-1:0] trial = cif.cmp ? sar_r : (sar_r & ~bit_r);
	wire [RW-1:0] msb = {1'b1, {(RW-1){1'b0}}};
	// phase sequencing runs by itself once started
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			E_IDLE: if (cif.start) st_nxt = E_TRACK;
			E_TRACK: if (acq_end) st_nxt = E_CONV;
			E_CONV: if (trial_end) st_nxt = E_IDLE;
			default: st_nxt = E_IDLE;
		endcase
	end
	// state and converter clock divider
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			st_r <= E_IDLE;
			div_cnt_r <= '0;
		end else begin
			st_r <= st_nxt;
			div_cnt_r <= (st_r == E_IDLE || tick) ? '0 : div_cnt_r + 1'b1;
		end
	end
	// acquisition clock count and sampling switch
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			acq_cnt_r <= '0;
			track_r <= 1'b0;
		end else begin
			track_r <= (st_nxt == E_TRACK);
			if (st_r != E_TRACK) acq_cnt_r <= '0;
			else if (tick) acq_cnt_r <= acq_cnt_r + 1'b1;
		end
	end
	// bit trials: keep the bit when the comparator says input is above
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			sar_r <= '0;
			bit_r <= '0;
			res_r <= '0;
			done_r <= 1'b0;
		end else begin
			done_r <= (st_r == E_CONV) && trial_end;
			if (st_r == E_TRACK && acq_end) begin
				sar_r <= msb;
				bit_r <= msb;
			end else if (st_r == E_CONV && tick) begin
				sar_r <= trial | (bit_r >> 1);
				bit_r <= bit_r >> 1;
				if (bit_r[0]) res_r <= trial;
			end
		end
	end
	// engine results out to the control block
	assign cif.track = track_r;
	assign cif.dac = sar_r;
	assign cif.result = res_r;
	assign cif.done = done_r;

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);
	// cycles spent tracking, for checking the programmed length
	logic [10:0] trk_cnt_r;
	wire [10:0] trk_want = ({9'h000, cif.acq_sel} + 11'h001) * ({3'h0, cif.clk_div} + 11'h001);
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) trk_cnt_r <= '0;
		else trk_cnt_r <= track_r ? trk_cnt_r + 11'h001 : 11'h000;
	end
	property p_track_first;
		(st_r == E_IDLE && cif.start) |=> track_r ##0 (st_r == E_TRACK);
	endproperty
	a_track_first: assert property (p_track_first) else $error("track not first");
	property p_hold_after;
		$fell(track_r) |-> (st_r == E_CONV) && (bit_r == msb);
	endproperty
	a_hold_after: assert property (p_hold_after) else $error("hold did not follow");
	property p_acq_len;
		$fell(track_r) |-> (trk_cnt_r == trk_want);
	endproperty
	a_acq_len: assert property (p_acq_len) else $error("track length wrong");
	property p_result;
		(st_r == E_CONV && trial_end) |=> done_r && (res_r == $past(trial));
	endproperty
	a_result: assert property (p_result) else $error("result not latched");
endmodule
`default_nettype wire

// ---- sac_cal_ctrl.sv ----
// calibration control with wishbone registers around the approximation engine
`timescale 1ns/1ps
`default_nettype none
module sac_cal_ctrl (
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic i_cmp,
	output logic o_track,
	output logic [sac_pkg::RES_W-1:0] o_dac_code,
	output logic [1:0] o_cal_mode,
	output logic o_busy
);
	typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_CONV = 3'b010, ST_CAL = 3'b100} sac_state_t;
	localparam int RW = sac_pkg::RES_W;
	localparam int SW = sac_pkg::SUM_W;

	sac_state_t state_r, state_nxt;
	logic ack_r;
	logic [31:0] rdat_r;
	logic [7:0] ctrl_r;
	logic [sac_pkg::ACQ_W-1:0] acq_r;
	logic [sac_pkg::DIV_W-1:0] div_r;
	logic [sac_pkg::CNT_W-1:0] left_r;
	logic [SW-1:0] sum_r, ofs_r, gain_r;
	logic go_r, busy_r, type_r;
	logic [1:0] calm_r;

	sac_conv_if cif();
	sac_sar_engine u_eng (
		.i_clock(i_clock),
		.i_sys_rst(i_sys_rst),
		.cif(cif.eng)
	);
	assign cif.start = go_r;
	assign cif.acq_sel = acq_r;
	assign cif.clk_div = div_r;
	assign cif.cmp = i_cmp;

	// bus decode: requests are acknowledged one cycle after they appear
	wire req = i_wb_cyc && i_wb_stb;
	wire wr_at = req && i_wb_we && ack_r;
	wire idle = (state_r == ST_IDLE);
	wire hit_ctrl = (i_wb_adr == sac_pkg::OFF_CAL_CTRL);
	wire hit_tim = (i_wb_adr == sac_pkg::OFF_TIMING);
	wire hit_conv = (i_wb_adr == sac_pkg::OFF_CONV);
	wire hit_res = (i_wb_adr == sac_pkg::OFF_RESULT);
	wire hit_ofs = (i_wb_adr == sac_pkg::OFF_OFS_COEF);
	wire hit_gain = (i_wb_adr == sac_pkg::OFF_GAIN_COEF);

	// configuration writes are taken only while nothing runs
	wire wr_ctrl = wr_at && hit_ctrl && i_wb_sel[0] && idle;
	wire wr_tim_lo = wr_at && hit_tim && i_wb_sel[0] && idle;
	wire wr_tim_hi = wr_at && hit_tim && i_wb_sel[1] && idle;
	wire start_req = wr_ctrl && i_wb_dat[sac_pkg::CC_START];
	wire conv_req = wr_at && hit_conv && i_wb_sel[0] && i_wb_dat[0] && idle;

	// readings to average for the code being written
	wire [1:0] avg_code = i_wb_dat[sac_pkg::CC_AVG_HI:sac_pkg::CC_AVG_LO];
	wire [sac_pkg::CNT_W-1:0] avg_n =
		(avg_code == 2'h0) ? sac_pkg::AVG_N00 :
		(avg_code == 2'h1) ? sac_pkg::AVG_N01 :
		(avg_code == 2'h2) ? sac_pkg::AVG_N10 : sac_pkg::AVG_N11;

	// engine completion events
	wire eng_done = cif.done;
	wire last = (left_r == {{(sac_pkg::CNT_W-1){1'b0}}, 1'b1});
	wire cal_step = (state_r == ST_CAL) && eng_done;
	wire cal_end = cal_step && last;
	wire [SW-1:0] sum_add = sum_r + {{(SW-RW){1'b0}}, cif.result};

	// read data selection, reserved bits read as zero
	wire [7:0] ctrl_rd = {busy_r, ctrl_r[6:0] & sac_pkg::CAL_CTRL_WMASK[6:0]};
	wire [31:0] rd_word =
		hit_ctrl ? {24'h000000, ctrl_rd} :
		hit_tim ? {16'h0000, div_r, 6'h00, acq_r} :
		hit_conv ? {31'h00000000, busy_r} :
		hit_res ? {{(32-RW){1'b0}}, cif.result} :
		hit_ofs ? {{(32-SW){1'b0}}, ofs_r} :
		hit_gain ? {{(32-SW){1'b0}}, gain_r} : 32'h00000000;

	// mode sequencer
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (start_req) state_nxt = ST_CAL;
				else if (conv_req) state_nxt = ST_CONV;
			end
			ST_CONV: if (eng_done) state_nxt = ST_IDLE;
			ST_CAL: if (cal_end) state_nxt = ST_IDLE;
			default: state_nxt = ST_IDLE;
		endcase
	end

	// bus handshake: ack for one cycle, read data with it
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			ack_r <= 1'b0;
			rdat_r <= 32'h00000000;
		end else begin
			ack_r <= req && !ack_r;
			if (req && !ack_r) rdat_r <= rd_word;
		end
	end

	// state and busy status
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			state_r <= ST_IDLE;
			busy_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			busy_r <= (state_nxt != ST_IDLE);
		end
	end

	// control register: start bit cleared by hardware at the end
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			ctrl_r <= sac_pkg::CAL_CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_r <= i_wb_dat[7:0] & sac_pkg::CAL_CTRL_WMASK;
		end else if (cal_end) begin
			ctrl_r[sac_pkg::CC_START] <= 1'b0;
		end
	end

	// timing register: acquisition clocks and converter clock divider
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			acq_r <= sac_pkg::ACQ_RST;
			div_r <= sac_pkg::DIV_RST;
		end else begin
			if (wr_tim_lo) acq_r <= i_wb_dat[sac_pkg::TM_ACQ_LSB +: sac_pkg::ACQ_W];
			if (wr_tim_hi) div_r <= i_wb_dat[sac_pkg::TM_DIV_LSB +: sac_pkg::DIV_W];
		end
	end

	// conversion launch: single request, calibration start, next reading
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) go_r <= 1'b0;
		else go_r <= start_req || conv_req || (cal_step && !last);
	end

	// averaging counter and running sum
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			left_r <= '0;
			sum_r <= '0;
		end else if (start_req) begin
			left_r <= avg_n;
			sum_r <= '0;
		end else if (cal_step) begin
			left_r <= left_r - 1'b1;
			sum_r <= sum_add;
		end
	end

	// calibration type and analog input select for the cycle
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			type_r <= 1'b0;
			calm_r <= sac_pkg::CALM_NONE;
		end else if (start_req) begin
			type_r <= i_wb_dat[sac_pkg::CC_TYPE];
			calm_r <= i_wb_dat[sac_pkg::CC_TYPE] ? sac_pkg::CALM_FULL : sac_pkg::CALM_ZERO;
		end else if (cal_end) begin
			calm_r <= sac_pkg::CALM_NONE;
		end
	end

	// coefficient store: summed readings of the finished cycle
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			ofs_r <= '0;
			gain_r <= '0;
		end else if (cal_end) begin
			if (type_r) gain_r <= sum_add;
			else ofs_r <= sum_add;
		end
	end

	// top-level outputs, each straight from a register
	assign o_wb_dat = rdat_r;
	assign o_wb_ack = ack_r;
	assign o_track = cif.track;
	assign o_dac_code = cif.dac;
	assign o_cal_mode = calm_r;
	assign o_busy = busy_r;

	// checks on the control side, all on the core clock
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);
	sequence s_launch;
		start_req;
	endsequence
	sequence s_cal_end;
		cal_end;
	endsequence
	property p_avg_fifteen;
		(s_launch and (avg_code == 2'h0)) |=> (left_r == 6'h0F);
	endproperty
	a_avg_fifteen: assert property (p_avg_fifteen) else $error("code 00 not fifteen");
	property p_avg_other;
		(s_launch and (avg_code != 2'h0)) |=> (left_r == (($past(avg_code) == 2'h1) ? 6'h01 :
			($past(avg_code) == 2'h2) ? 6'h1F : 6'h3F));
	endproperty
	a_avg_other: assert property (p_avg_other) else $error("averaging count wrong");
	property p_busy_run;
		s_launch |=> busy_r [*3];
	endproperty
	a_busy_run: assert property (p_busy_run) else $error("busy not held");
	property p_cal_finish;
		s_cal_end |=> !busy_r && !ctrl_r[sac_pkg::CC_START] && (state_r == ST_IDLE);
	endproperty
	a_cal_finish: assert property (p_cal_finish) else $error("start or busy not cleared");
	property p_cal_type;
		(state_r == ST_CAL) |-> (o_cal_mode == (type_r ? 2'h2 : 2'h1));
	endproperty
	a_cal_type: assert property (p_cal_type) else $error("calibration type wrong");
	property p_launch;
		s_launch |=> (state_r == ST_CAL) && ctrl_r[sac_pkg::CC_START] && go_r;
	endproperty
	a_launch: assert property (p_launch) else $error("calibration not launched");
	property p_next_reading;
		(cal_step && !last) |=> go_r && (left_r == $past(left_r) - 6'h01);
	endproperty
	a_next_reading: assert property (p_next_reading) else $error("next reading missing");
	// single conversion: busy from the launch until the engine reports done
	sequence s_conv_launch;
		conv_req;
	endsequence
	sequence s_conv_end;
		(state_r == ST_CONV) && eng_done;
	endsequence
	property p_conv_busy;
		s_conv_launch |=> busy_r && (state_r == ST_CONV) && go_r;
	endproperty
	a_conv_busy: assert property (p_conv_busy) else $error("conversion did not raise busy");
	property p_conv_idle;
		s_conv_end |=> !busy_r && (state_r == ST_IDLE);
	endproperty
	a_conv_idle: assert property (p_conv_idle) else $error("busy not cleared after conversion");
	property p_busy_state;
		busy_r == (state_r != ST_IDLE);
	endproperty
	a_busy_state: assert property (p_busy_state) else $error("busy disagrees with state");
	// the start bit stays set for the whole calibration
	property p_start_held;
		(state_r == ST_CAL) |-> ctrl_r[sac_pkg::CC_START];
	endproperty
	a_start_held: assert property (p_start_held) else $error("start bit dropped early");
	// the finished sum goes to the coefficient of the selected type only
	property p_gain_store;
		(s_cal_end and type_r) |=> (gain_r == $past(sum_add)) && $stable(ofs_r);
	endproperty
	a_gain_store: assert property (p_gain_store) else $error("gain coefficient not stored");
	property p_ofs_store;
		(s_cal_end and !type_r) |=> (ofs_r == $past(sum_add)) && $stable(gain_r);
	endproperty
	a_ofs_store: assert property (p_ofs_store) else $error("offset coefficient not stored");
	property p_mode_clear;
		s_cal_end |=> (o_cal_mode == sac_pkg::CALM_NONE);
	endproperty
	a_mode_clear: assert property (p_mode_clear) else $error("input select not released");
	property p_sum_step;
		cal_step |=> (sum_r == $past(sum_add));
	endproperty
	a_sum_step: assert property (p_sum_step) else $error("reading not summed");
	// a write while a cycle runs leaves the settings alone
	property p_cfg_frozen;
		(wr_at && !idle) |=> $stable(ctrl_r[5:1]) && $stable(acq_r) && $stable(div_r);
	endproperty
	a_cfg_frozen: assert property (p_cfg_frozen) else $error("setting changed while busy");
	// each request gets a single one-cycle acknowledge
	property p_ack_once;
		o_wb_ack |=> !o_wb_ack;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("acknowledge held too long");
	// readings finished in the running calibration, counted apart from left_r
	logic [1:0] code_r;
	logic [sac_pkg::CNT_W-1:0] seen_r;
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			code_r <= 2'h0;
			seen_r <= '0;
		end else if (start_req) begin
			code_r <= avg_code;
			seen_r <= '0;
		end else if (cal_step) begin
			seen_r <= seen_r + 1'b1;
		end
	end
	property p_reading_count;
		s_cal_end |-> ((seen_r + 6'h01) ==
			((code_r == 2'h0) ? 6'h0F : (code_r == 2'h1) ? 6'h01 :
			(code_r == 2'h2) ? 6'h1F : 6'h3F));
	endproperty
	a_reading_count: assert property (p_reading_count) else $error("reading count wrong");
endmodule
`default_nettype wire

// ---- sar_adc_calibration_control_test.sv ----
// self-checking bench for the converter calibration control block
`timescale 1ns/1ps
`default_nettype none
module sar_adc_calibration_control_test;
	logic i_clock = 1'b0;
	logic i_sys_rst = 1'b1;
	logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, i_cmp = 1'b0, trk_d = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_dat = 32'h00000000, rd, lfsr = 32'h00013D49;
	logic [31:0] o_wb_dat;
	logic o_wb_ack, o_track, o_busy;
	logic [11:0] o_dac_code, vin = 12'h000;
	logic [1:0] o_cal_mode;
	int miscompares = 0, total_checks = 0, nconv = 0, tcnt = 0, tlen = 0;
	int navg[4] = '{15, 1, 31, 63};
	int exp_q[$];
	// free-running core clock, 25 ns period
	always #12.5 i_clock = ~i_clock;
	sac_cal_ctrl sac_cal_ctrl_i (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_wb_cyc(wb_cyc),
		.i_wb_stb(wb_stb), .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_sel(wb_sel),
		.i_wb_dat(wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_cmp(i_cmp),
		.o_track(o_track), .o_dac_code(o_dac_code), .o_cal_mode(o_cal_mode), .o_busy(o_busy));
	// verdict and end of run
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// compare one value and count it
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	function automatic logic [31:0] nxt(input logic [31:0] l);
		return {l[30:0], l[31] ^ l[21] ^ l[1] ^ l[0]};
	endfunction
	// comparator stand-in: analog level vin against the trial code; phase counters
	always @(posedge i_clock) begin
		i_cmp <= (vin >= o_dac_code);
		trk_d <= o_track;
		if (o_track === 1'b1) begin
			tcnt <= (trk_d !== 1'b1) ? 1 : tcnt + 1;
		end
		if (o_track === 1'b1 && trk_d !== 1'b1) begin
			nconv <= nconv + 1;
		end
		if (o_track === 1'b0 && trk_d === 1'b1) begin
			tlen <= tcnt;
			chk("hold_first_trial", 32'(o_dac_code), 32'h00000800);
		end
	end
	// one classic wishbone cycle; read data lands in rd
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge i_clock);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat <= d;
		wb_sel <= 4'h3;
		n = 0;
		do begin
			@(posedge i_clock);
			n++;
		end while (o_wb_ack !== 1'b1 && n < 100);
		if (n >= 100) begin
			miscompares++;
			close_out();
		end
		rd = o_wb_dat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
	endtask
	// busy pin and input select while running, then bounded wait for the end
	task automatic wait_idle(input logic [1:0] mode);
		int n;
		repeat (2) @(posedge i_clock);
		chk("busy_pin", 32'(o_busy), 32'h00000001);
		chk("cal_mode", 32'(o_cal_mode), 32'(mode));
		n = 0;
		while (o_busy !== 1'b0 && n < 20000) begin
			@(posedge i_clock);
			n++;
		end
		if (n >= 20000) begin
			miscompares++;
			close_out();
		end
		chk("cal_mode_end", 32'(o_cal_mode), 32'h00000000);
	endtask
	// single conversion at a given timing, with a rejected write while busy
	task automatic conv(input logic [1:0] acq, input logic [7:0] dv);
		logic [31:0] t;
		t = {16'h0000, dv, 6'h00, acq};
		lfsr = nxt(lfsr);
		vin = lfsr[11:0];
		exp_q.push_back(vin);
		wb(1'b1, sac_pkg::OFF_TIMING, t);
		wb(1'b1, sac_pkg::OFF_CONV, 32'h00000001);
		wb(1'b0, sac_pkg::OFF_CONV, 32'h00000000);
		chk("busy_read", rd, 32'h00000001);
		wb(1'b1, sac_pkg::OFF_TIMING, 32'h0000FF03);
		wait_idle(sac_pkg::CALM_NONE);
		wb(1'b0, sac_pkg::OFF_RESULT, 32'h00000000);
		chk("result", rd, 32'(exp_q.pop_front()));
		chk("track_len", 32'(tlen), 32'((acq + 1) * (dv + 1)));
		wb(1'b0, sac_pkg::OFF_TIMING, 32'h00000000);
		chk("timing_kept", rd, t);
	endtask
	// calibration of one type with one averaging code
	task automatic cal(input logic [1:0] code, input logic typ);
		int n0;
		int e;
		lfsr = nxt(lfsr);
		vin = lfsr[11:0];
		n0 = nconv;
		e = vin * navg[code];
		// bit three written zero, bit two written one on launch
		wb(1'b1, sac_pkg::OFF_CAL_CTRL, {26'h0, code, 1'b0, 1'b1, typ, 1'b1});
		wb(1'b0, sac_pkg::OFF_CAL_CTRL, 32'h00000000);
		chk("ctrl_running", rd, {24'h0, 2'h2, code, 1'b0, 1'b1, typ, 1'b1});
		wait_idle(typ ? sac_pkg::CALM_FULL : sac_pkg::CALM_ZERO);
		chk("readings", 32'(nconv - n0), 32'(navg[code]));
		wb(1'b0, typ ? sac_pkg::OFF_GAIN_COEF : sac_pkg::OFF_OFS_COEF, 32'h00000000);
		chk("coef", rd, 32'(e));
		wb(1'b0, sac_pkg::OFF_CAL_CTRL, 32'h00000000);
		chk("ctrl_done", rd, {24'h0, 2'h0, code, 1'b0, 1'b1, typ, 1'b0});
	endtask
	// main sequence
	initial begin
		repeat (6) @(posedge i_clock);
		i_sys_rst <= 1'b0;
		wb(1'b0, sac_pkg::OFF_CAL_CTRL, 32'h00000000);
		chk("ctrl_reset", rd, 32'h00000000);
		wb(1'b0, sac_pkg::OFF_TIMING, 32'h00000000);
		chk("timing_reset", rd, 32'h00000702);
		wb(1'b0, sac_pkg::OFF_RESULT, 32'h00000000);
		chk("result_reset", rd, 32'h00000000);
		wb(1'b1, 8'h20, 32'hFFFFFFFF);
		wb(1'b0, 8'h20, 32'h00000000);
		chk("unmapped", rd, 32'h00000000);
		wb(1'b1, sac_pkg::OFF_CONV, 32'h00000000);
		repeat (3) @(posedge i_clock);
		chk("no_launch", 32'(o_busy), 32'h00000000);
		$display("test reset_and_map done");
		conv(2'h0, 8'h03);
		conv(2'h3, 8'h05);
		for (int k = 0; k < 4; k++) begin
			lfsr = nxt(lfsr);
			conv(lfsr[13:12], {5'h00, lfsr[16:14]} + 8'h02);
		end
		$display("test conversion done");
		wb(1'b1, sac_pkg::OFF_TIMING, 32'h00000300);
		for (int c = 0; c < 4; c++) begin
			for (int t = 0; t < 2; t++) begin
				cal(2'(c), 1'(t));
			end
		end
		$display("test calibration done");
		close_out();
	end
endmodule
`default_nettype wire
